// >>> rtl/crcp_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - shift-order bit clear feeds MSb first; set feeds LSb first.
// - LSb-first changes only input order; result stays a normal CRC.
// - irq select 0: interrupt when word count goes from 1 to 0.
// - irq select 1: interrupt when hardware loads the last word and clears shift-run.
// - software clearing shift-run gives no interrupt.
// - after that interrupt, shifting goes on (width field+2)/2 more cycles.
// - two-half input pair and two-half result pair exist.
// - fifo depth 4 for width field >15, 8 for 8..15, 16 below 8.
// - word count rises when the width's MSb half is written.
// - shift while run set and words exist, up to two bits per cycle.
// - module enable low empties the fifo and holds count at zero.
module crcp_engine
  import crcp_pkg::*;
#(
  parameter int unsigned MAX_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  output logic crc_irq
);
  logic en_q, en_d, idle_q, idle_d, isel_q, isel_d;
  logic run_q, run_d, lsbf_q, lsbf_d;
  logic [4:0] dw_q, dw_d, pl_q, pl_d;
  logic [31:0] poly_q, poly_d, crc_q, crc_d, sh_q, sh_d;
  logic [15:0] dlo_q, dlo_d, dhi_q, dhi_d;
  logic [31:0] mem_q [MAX_DEPTH];
  logic [31:0] mem_d [MAX_DEPTH];
  logic [3:0] wp_q, wp_d, rp_q, rp_d;
  logic [4:0] cnt_q, cnt_d;
  logic [5:0] rem_q, rem_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d, irq_q, irq_d;
  logic wr, setup, halt, full, push, pop, load, mapped;
  logic [31:0] rd_val;

  crcp_stream_if #(.W(32)) f2b ();
  crcp_stream_if #(.W(32)) b2s ();

  crcp_buf2 #(.W(32)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!en_q),
    .up(f2b.snk),
    .dn(b2s.src)
  );

  // depth follows the configured data width
  function automatic logic [4:0] depth_of(input logic [4:0] dw);
    if (dw >= CRCP_DW_WIDE_MIN) begin
      return CRCP_DEPTH_WIDE;
    end else if (dw >= CRCP_DW_MID_MIN) begin
      return CRCP_DEPTH_MID;
    end else begin
      return CRCP_DEPTH_NARROW;
    end
  endfunction

  // one non-direct step: data enters at bit 0 and bit pl feeds back, so
  // software must flush length+1 zero bits through to get the final crc
  function automatic logic [31:0] crc_bit(input logic [31:0] crc,
      input logic [31:0] poly, input logic [4:0] pl, input logic din);
    logic fb;
    logic [31:0] nx;
    fb = crc[pl];
    nx = {crc[30:0], din};
    if (fb) begin
      nx = nx ^ {poly[31:1], 1'b1};
    end
    return nx & (CRCP_ALL_ONES >> (5'd31 - pl));
  endfunction

  // data bit taken from the word, by order; crc math is unchanged
  function automatic logic pick_bit(input logic [31:0] sh,
      input logic [4:0] dw, input logic lsbf);
    return lsbf ? sh[0] : sh[dw];
  endfunction

  function automatic logic [31:0] drop_bit(input logic [31:0] sh,
      input logic lsbf);
    return lsbf ? {1'b0, sh[31:1]} : {sh[30:0], 1'b0};
  endfunction

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign halt = idle_q && cpu_idle;
  assign full = (cnt_q >= depth_of(dw_q));
  assign f2b.valid = (cnt_q != 5'h00) && en_q && run_q && !halt;
  assign f2b.data = mem_q[rp_q];
  assign f2b.more = 1'b0;
  assign pop = f2b.valid && f2b.ready;
  // a new word enters only when the shifter is free
  assign load = b2s.valid && b2s.ready;
  assign b2s.ready = (rem_q == 6'h00) && run_q && en_q && !halt;

  // bus decode and read mux; status fields are hardware owned
  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    case (paddr)
      CRCP_OFF_CON1: begin
        rd_val[CRCP_EN_BIT] = en_q;
        rd_val[CRCP_IDLE_BIT] = idle_q;
        rd_val[CRCP_CNT_LSB +: CRCP_FIELD_W] = cnt_q;
        rd_val[CRCP_FULL_BIT] = full;
        rd_val[CRCP_EMPTY_BIT] = (cnt_q == 5'h00);
        rd_val[CRCP_ISEL_BIT] = isel_q;
        rd_val[CRCP_RUN_BIT] = run_q;
        rd_val[CRCP_LSBF_BIT] = lsbf_q;
      end
      CRCP_OFF_CON2: begin
        rd_val[CRCP_DW_LSB +: CRCP_FIELD_W] = dw_q;
        rd_val[CRCP_PL_LSB +: CRCP_FIELD_W] = pl_q;
      end
      CRCP_OFF_XORL: rd_val[15:0] = {poly_q[15:1], 1'b0};
      CRCP_OFF_XORH: rd_val[15:0] = poly_q[31:16];
      CRCP_OFF_DATL: rd_val[15:0] = dlo_q;
      CRCP_OFF_DATH: rd_val[15:0] = dhi_q;
      CRCP_OFF_WDATL: rd_val[15:0] = crc_q[15:0];
      CRCP_OFF_WDATH: rd_val[15:0] = crc_q[31:16];
      default: mapped = 1'b0;
    endcase
  end

  // next state of registers, fifo, shifter and interrupt
  always_comb begin
    en_d = en_q;
    idle_d = idle_q;
    isel_d = isel_q;
    run_d = run_q;
    lsbf_d = lsbf_q;
    dw_d = dw_q;
    pl_d = pl_q;
    poly_d = poly_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    crc_d = crc_q;
    sh_d = sh_q;
    rem_d = rem_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    irq_d = 1'b0;
    push = 1'b0;
    prdata_d = setup ? rd_val : prdata_q;
    pslverr_d = setup ? !mapped : pslverr_q;
    // shifter: up to two bits per cycle, finishes its word even if run drops
    if (rem_q != 6'h00 && !halt) begin
      crc_d = crc_bit(crc_q, poly_q, pl_q, pick_bit(sh_q, dw_q, lsbf_q));
      sh_d = drop_bit(sh_q, lsbf_q);
      rem_d = rem_q - 6'd1;
      if (rem_q != 6'd1) begin
        crc_d = crc_bit(crc_d, poly_q, pl_q, pick_bit(sh_d, dw_q, lsbf_q));
        sh_d = drop_bit(sh_d, lsbf_q);
        rem_d = rem_q - 6'd2;
      end
    end
    if (load) begin
      sh_d = b2s.data;
      rem_d = {1'b0, dw_q} + 6'd1;
      // last word taken: hardware ends the run, the word still shifts out
      if (isel_q && cnt_q == 5'h00 && !b2s.more) begin
        run_d = 1'b0;
        irq_d = 1'b1;
      end
    end
    if (pop) begin
      rp_d = rp_q + 4'd1;
    end
    // software writes; clearing shift-run never raises the interrupt
    if (wr) begin
      case (paddr)
        CRCP_OFF_CON1: begin
          en_d = pwdata[CRCP_EN_BIT];
          idle_d = pwdata[CRCP_IDLE_BIT];
          isel_d = pwdata[CRCP_ISEL_BIT];
          run_d = pwdata[CRCP_RUN_BIT];
          lsbf_d = pwdata[CRCP_LSBF_BIT];
        end
        CRCP_OFF_CON2: begin
          dw_d = pwdata[CRCP_DW_LSB +: CRCP_FIELD_W];
          pl_d = pwdata[CRCP_PL_LSB +: CRCP_FIELD_W];
        end
        CRCP_OFF_XORL: poly_d[15:1] = pwdata[15:1];
        CRCP_OFF_XORH: poly_d[31:16] = pwdata[15:0];
        CRCP_OFF_DATL: begin
          dlo_d = pwdata[15:0];
          push = (dw_q <= CRCP_DW_SPLIT);
        end
        CRCP_OFF_DATH: begin
          dhi_d = pwdata[15:0];
          push = (dw_q > CRCP_DW_SPLIT);
        end
        CRCP_OFF_WDATL: crc_d[15:0] = pwdata[15:0];
        CRCP_OFF_WDATH: crc_d[31:16] = pwdata[15:0];
        default: ;
      endcase
    end
    // a write to a full fifo is dropped
    push = push && !full && en_q;
    if (push) begin
      mem_d[wp_q] = {dhi_d, dlo_d};
      wp_d = wp_q + 4'd1;
    end
    cnt_d = cnt_q + {4'h0, push} - {4'h0, pop};
    // only a real fall from one to zero; a refill in the same cycle is not
    if (!isel_q && cnt_q == 5'h01 && cnt_d == 5'h00) begin
      irq_d = 1'b1;
    end
    // disabled: pointers, shifter and result reset
    if (!en_q) begin
      wp_d = 4'h0;
      rp_d = 4'h0;
      cnt_d = 5'h00;
      rem_d = 6'h00;
      crc_d = '0;
      dhi_d = '0;
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      idle_q <= 1'b0;
      isel_q <= 1'b0;
      run_q <= 1'b0;
      lsbf_q <= 1'b0;
      dw_q <= '0;
      pl_q <= '0;
      poly_q <= '0;
      dlo_q <= '0;
      dhi_q <= '0;
      crc_q <= '0;
      sh_q <= '0;
      rem_q <= '0;
      mem_q <= '{default: '0};
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      idle_q <= idle_d;
      isel_q <= isel_d;
      run_q <= run_d;
      lsbf_q <= lsbf_d;
      dw_q <= dw_d;
      pl_q <= pl_d;
      poly_q <= poly_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      crc_q <= crc_d;
      sh_q <= sh_d;
      rem_q <= rem_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // zero wait states: data was captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign crc_irq = irq_q;
endmodule // crcp_engine
`default_nettype wire

// >>> rtl/crcp_pkg.sv
package crcp_pkg;
  localparam int unsigned CRCP_DATA_W = 32;
  localparam int unsigned CRCP_HALF_W = 16;
  localparam int unsigned CRCP_FIELD_W = 5;
  // register byte offsets on the bus
  localparam logic [7:0] CRCP_OFF_CON1 = 8'h00;
  localparam logic [7:0] CRCP_OFF_CON2 = 8'h04;
  localparam logic [7:0] CRCP_OFF_XORL = 8'h08;
  localparam logic [7:0] CRCP_OFF_XORH = 8'h0C;
  localparam logic [7:0] CRCP_OFF_DATL = 8'h10;
  localparam logic [7:0] CRCP_OFF_DATH = 8'h14;
  localparam logic [7:0] CRCP_OFF_WDATL = 8'h18;
  localparam logic [7:0] CRCP_OFF_WDATH = 8'h1C;
  // control/status field positions
  localparam int unsigned CRCP_EN_BIT = 15;
  localparam int unsigned CRCP_IDLE_BIT = 13;
  localparam int unsigned CRCP_CNT_LSB = 8;
  localparam int unsigned CRCP_FULL_BIT = 7;
  localparam int unsigned CRCP_EMPTY_BIT = 6;
  localparam int unsigned CRCP_ISEL_BIT = 5;
  localparam int unsigned CRCP_RUN_BIT = 4;
  localparam int unsigned CRCP_LSBF_BIT = 3;
  // second control register field positions
  localparam int unsigned CRCP_DW_LSB = 8;
  localparam int unsigned CRCP_PL_LSB = 0;
  // fifo depth per data width
  localparam logic [4:0] CRCP_DEPTH_WIDE = 5'h04;
  localparam logic [4:0] CRCP_DEPTH_MID = 5'h08;
  localparam logic [4:0] CRCP_DEPTH_NARROW = 5'h10;
  localparam logic [4:0] CRCP_DW_MID_MIN = 5'h08;
  localparam logic [4:0] CRCP_DW_WIDE_MIN = 5'h10;
  localparam logic [4:0] CRCP_DW_SPLIT = 5'h0F;
  localparam logic [31:0] CRCP_ALL_ONES = 32'hFFFFFFFF;
endpackage

// >>> rtl/crcp_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crcp_stream_if #(parameter int unsigned W = 32);
  logic valid;
  logic ready;
  logic more;
  logic [W-1:0] data;
  modport src (output valid, output data, output more, input ready);
  modport snk (input valid, input data, input more, output ready);
endinterface
`default_nettype wire

// >>> rtl/crcp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer between the word fifo and the shifter
module crcp_buf2 #(
  parameter int unsigned W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  crcp_stream_if.snk up,
  crcp_stream_if.src dn
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign up.ready = (cnt_q != 2'h2);
  assign dn.valid = (cnt_q != 2'h0);
  assign dn.data = mem_q[rp_q];
  assign dn.more = (cnt_q == 2'h2);
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // next state; a flush drops both entries
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      wp_d = 1'b0;
      rp_d = 1'b0;
      cnt_d = 2'h0;
    end else begin
      if (push) begin
        mem_d[wp_q] = up.data;
        wp_d = ~wp_q;
      end
      if (pop) begin
        rp_d = ~rp_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // crcp_buf2
`default_nettype wire

// >>> tb/crcp_engine_properties.sv
`timescale 1ns/1ps
`default_nettype none
module crcp_engine_props
  import crcp_pkg::*;
#(
  parameter int unsigned MAX_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic crc_irq
);
  logic en_q;
  logic en_d;
  logic [4:0] dw_q;
  logic [4:0] dw_d;
  logic [4:0] dep;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow of enable and width, as software last wrote them
  always_comb begin
    en_d = en_q;
    dw_d = dw_q;
    if (psel && penable && pwrite && paddr == CRCP_OFF_CON1)
      en_d = pwdata[CRCP_EN_BIT];
    if (psel && penable && pwrite && paddr == CRCP_OFF_CON2)
      dw_d = pwdata[12:8];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      dw_q <= 5'h00;
    end else begin
      en_q <= en_d;
      dw_q <= dw_d;
    end
  end
  // depth only valid while the width is not changed to a depth below the word count
  assign dep = (dw_q >= CRCP_DW_WIDE_MIN) ? CRCP_DEPTH_WIDE :
    (dw_q >= CRCP_DW_MID_MIN) ? CRCP_DEPTH_MID : CRCP_DEPTH_NARROW;
  sequence s_ctl_wr;
    psel && penable && pwrite && paddr == CRCP_OFF_CON1;
  endsequence
  sequence s_ctl_rd;
    psel && penable && !pwrite && paddr == CRCP_OFF_CON1;
  endsequence
  AST_IRQ_PULSE: assert property (crc_irq |=> !crc_irq)
    else $error("irq wider than one cycle");
  AST_DIS_QUIET: assert property (s_ctl_wr ##0 !pwdata[CRCP_EN_BIT]
    |-> ##2 !crc_irq[*2]) else $error("irq after disable");
  AST_SW_STOP: assert property (s_ctl_wr ##0 (pwdata[5:4] == 2'h2)
    |-> ##2 !crc_irq[*2]) else $error("irq after software stop");
  AST_CNT_MAX: assert property (s_ctl_rd |-> prdata[12:8] <= MAX_DEPTH)
    else $error("count above depth");
  AST_FULL_DEPTH: assert property (s_ctl_rd ##0 prdata[CRCP_FULL_BIT]
    |-> prdata[12:8] == dep) else $error("full at wrong count");
  AST_EMPTY_CNT: assert property (s_ctl_rd
    |-> prdata[CRCP_EMPTY_BIT] == (prdata[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  AST_DIS_EMPTY: assert property (s_ctl_rd ##0 (!en_q && !$past(en_q, 2))
    |-> prdata[15:6] == 10'h001) else $error("disabled fifo not empty");
  AST_RSVD_ZERO: assert property (s_ctl_rd
    |-> prdata[31:16] == 16'h0000 && !prdata[14] && prdata[2:0] == 3'h0)
    else $error("reserved bits set");
  AST_BAD_ADDR: assert property (psel && penable && paddr[7:5] != 3'h0
    |-> pslverr) else $error("unmapped access not refused");
  AST_GOOD_ADDR: assert property (psel && penable && paddr[7:5] == 3'h0
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
endmodule // crcp_engine_props
bind crcp_engine crcp_engine_props #(.MAX_DEPTH(MAX_DEPTH)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .cpu_idle, .crc_irq);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crcp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cpu_idle = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, res;
  logic pready, pslverr, crc_irq, er;
  int fails = 0;
  int n_checks = 0;
  int nirq = 0;
  logic [31:0] words [4];
  logic [4:0] wtab [4] = '{5'h10, 5'h0F, 5'h08, 5'h07};
  logic [4:0] dtab [4] = '{5'h04, 5'h08, 5'h08, 5'h10};
  crcp_engine u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_idle, .crc_irq);
  always #5 pclk = ~pclk;
  // pulses are counted so extra or missing ones show up later
  always @(posedge pclk) if (crc_irq === 1'b1) nirq <= nirq + 1;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // one transfer, always followed by an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 100 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 100) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic con1(input logic [15:0] v);
    apb(1'b1, CRCP_OFF_CON1, {16'h0, v});
  endtask
  // wide words are only counted once the high half lands
  task automatic push(input logic [31:0] d, input logic [4:0] w);
    apb(1'b1, CRCP_OFF_DATL, {16'h0, d[15:0]});
    if (w > 5'h0F) apb(1'b1, CRCP_OFF_DATH, {16'h0, d[31:16]});
  endtask
  task automatic wait_irq(input int n0);
    for (int i = 0; i < 3000 && nirq == n0; i++) @(posedge pclk);
    chk("irq", 32'h1, nirq - n0);
  endtask
  // shift register as seen by software, seed not augmented
  function automatic logic [31:0] model(input logic [31:0] c, p,
      input int l, w, n, input logic lf);
    logic b, t;
    for (int k = 0; k < n; k++)
      for (int i = 0; i < w; i++) begin
        b = lf ? words[k][i] : words[k][w-1-i];
        t = c[l-1];
        c = {c[30:0], b};
        if (t) c = c ^ p ^ {31'h0, ~p[0]};
      end
    return c & (CRCP_ALL_ONES >> (32 - l));
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    print_verdict;
  end
  initial begin
    logic [4:0] dw, pl;
    logic [31:0] poly, init, crc_raw;
    logic lf, isel;
    int n, k;
    void'($urandom(59152));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CRCP_OFF_CON1, 32'h0);
    chk("ctrl_rst", 32'h40, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, er);
    // fill each width class until full, status bits written as ones
    foreach (wtab[j]) begin
      con1(16'h0000);
      con1(16'h9FC0);
      apb(1'b0, CRCP_OFF_CON1, 32'h0);
      chk("ctrl_ro", 32'h8040, rd);
      apb(1'b1, CRCP_OFF_CON2, {19'h0, wtab[j], 8'h00});
      k = 0;
      while (k < 20 && rd[CRCP_FULL_BIT] !== 1'b1) begin
        push($urandom, wtab[j]);
        k++;
        apb(1'b0, CRCP_OFF_CON1, 32'h0);
      end
      chk("depth", dtab[j], k);
      chk("count", dtab[j], rd[12:8]);
      con1(16'h0000);
      apb(1'b0, CRCP_OFF_CON1, 32'h0);
      chk("dis_ctrl", 32'h40, rd);
      apb(1'b0, CRCP_OFF_WDATL, 32'h0);
      chk("dis_res", 32'h0, rd);
    end
    // random checksums, widest and narrowest first
    for (int t = 0; t < 14; t++) begin
      dw = (t == 0) ? 5'h1F : (t == 1) ? 5'h00 : 5'($urandom);
      pl = (t == 0) ? 5'h1F : (t == 1) ? 5'h00 : 5'($urandom);
      poly = $urandom;
      init = $urandom;
      lf = 1'($urandom);
      isel = 1'($urandom);
      n = 1 + $urandom % 4;
      cpu_idle <= 1'($urandom);
      for (k = 0; k < n; k++) words[k] = $urandom & (CRCP_ALL_ONES >> (31 - dw));
      con1(16'h0000);
      con1(16'h8000);
      apb(1'b1, CRCP_OFF_CON2, {19'h0, dw, 3'h0, pl});
      apb(1'b1, CRCP_OFF_XORL, {16'h0, poly[15:0]});
      apb(1'b1, CRCP_OFF_XORH, {16'h0, poly[31:16]});
      con1({10'h200, isel, 1'b0, lf, 3'h0});
      apb(1'b1, CRCP_OFF_WDATL, {16'h0, init[15:0]});
      apb(1'b1, CRCP_OFF_WDATH, {16'h0, init[31:16]});
      for (k = 0; k < n; k++) push(words[k], dw);
      k = nirq;
      con1({10'h200, isel, 1'b1, lf, 3'h0});
      wait_irq(k);
      repeat (isel ? (dw + 2) / 2 : 3 * ((dw + 2) / 2) + 6) @(posedge pclk);
      apb(1'b0, CRCP_OFF_CON1, 32'h0);
      chk("empty", 32'h1, rd[CRCP_EMPTY_BIT]);
      apb(1'b0, CRCP_OFF_WDATL, 32'h0);
      res = rd;
      apb(1'b0, CRCP_OFF_WDATH, 32'h0);
      crc_raw = model(init, poly, pl + 1, dw + 1, n, lf);
      chk("crc", crc_raw, {rd[15:0], res[15:0]});
      apb(1'b0, CRCP_OFF_CON1, 32'h0);
      if (isel) chk("run_clr", 32'h0, rd[CRCP_RUN_BIT]);
      chk("irq_once", k + 1, nirq);
      // raw value is non-direct: flush length+1 zero bits to finish it
      k = nirq;
      con1({10'h200, 1'b0, 1'b0, lf, 3'h0});
      apb(1'b1, CRCP_OFF_CON2, {19'h0, pl, 3'h0, pl});
      push(32'h0, pl);
      chk("sw_stop", k, nirq);
      con1({10'h200, 1'b0, 1'b1, lf, 3'h0});
      wait_irq(k);
      repeat ((pl + 2) / 2 + 2) @(posedge pclk);
      apb(1'b0, CRCP_OFF_WDATL, 32'h0);
      res = rd;
      apb(1'b0, CRCP_OFF_WDATH, 32'h0);
      words[0] = 32'h0;
      chk("crc_fin", model(crc_raw, poly, pl + 1, pl + 1, 1, lf),
        {rd[15:0], res[15:0]});
    end
    // halted while idle with the stop bit set
    cpu_idle <= 1'b1;
    con1(16'h0000);
    con1(16'hA000);
    apb(1'b1, CRCP_OFF_CON2, 32'h0707);
    push(32'h5A, 5'h07);
    k = nirq;
    con1(16'hA010);
    repeat (30) @(posedge pclk);
    apb(1'b0, CRCP_OFF_CON1, 32'h0);
    chk("idle_cnt", 32'h1, rd[12:8]);
    chk("idle_irq", k, nirq);
    cpu_idle <= 1'b0;
    wait_irq(k);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
